// file: core/fplb_pkg.sv
// fplb_pkg: shared constants and types for the fault/peak log controller
// assumes a single 40 MHz system clock domain
package fplb_pkg;
    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned WINDOW_SEC    = 30;
    localparam int unsigned WINDOW_CYC    = CLK_HZ * WINDOW_SEC;
    localparam int unsigned NUM_RAILS     = 12;
    localparam int unsigned RAIL_W        = 4;
    localparam int unsigned NUM_QTY       = 3;
    localparam int unsigned QTY_W         = 2;
    localparam int unsigned MEAS_W        = 12;
    localparam int unsigned TYPE_W        = 4;
    localparam int unsigned RTC_W         = 32;
    localparam int unsigned RST_CNT_W     = 16;
    localparam int unsigned NUM_FAULTS    = 10;
    localparam int unsigned FIDX_W        = 4;
    localparam int unsigned NUM_PEAKS     = NUM_RAILS * NUM_QTY;
    localparam int unsigned PIDX_W        = 6;
    localparam int unsigned FREC_W        = RAIL_W + TYPE_W + RTC_W + MEAS_W;
    // brownout threshold, supply code in mV
    localparam logic [MEAS_W-1:0] BROWNOUT_MV = 12'hb54;
    localparam logic [RST_CNT_W-1:0] RST_CNT_INIT = 16'h0000;
    localparam logic [RTC_W-1:0]     RTC_INIT     = 32'h0000_0000;
    localparam logic [MEAS_W-1:0]    PEAK_INIT    = 12'h000;

    // flash write kinds
    localparam logic [1:0] FW_PEAK  = 2'h0;
    localparam logic [1:0] FW_FAULT = 2'h1;
    localparam logic [1:0] FW_RSTC  = 2'h2;
    localparam logic [1:0] FW_RTC   = 2'h3;

    typedef enum logic [3:0] {
        FPLB_IDLE  = 4'b0001,
        FPLB_BOOT  = 4'b0010,
        FPLB_WRITE = 4'b0100,
        FPLB_DUMP  = 4'b1000
    } fplb_state_t;
endpackage

// file: core/fplb_win_if.sv
// fplb_win_if: signals between the top and one peak window
// assumes both ends sit on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface fplb_win_if;
    logic                              samp_vld;
    logic [fplb_pkg::MEAS_W-1:0]       samp;
    logic [fplb_pkg::MEAS_W-1:0]       logged;
    logic                              expire;
    logic [fplb_pkg::MEAS_W-1:0]       peak;
    logic                              done;
    modport win (input samp_vld, input samp, input logged, input done, output expire, output peak);
    modport ctl (output samp_vld, output samp, output logged, output done, input expire, input peak);
endinterface
`default_nettype wire

// file: core/fplb_peak_win.sv
// fplb_peak_win: one 30 s peak-throttle window for one rail and quantity
// assumes samples arrive from same-clock logic; done acknowledges expire
`timescale 1ns/100ps
`default_nettype none
module fplb_peak_win #(
    parameter int unsigned WIN_CYC = fplb_pkg::WINDOW_CYC
) (
    input  wire logic     clk_sys, // system clock
    input  wire logic     sys_rst, // sync reset
    fplb_win_if.win       w        // window link
);
    logic                        run_q;
    logic [31:0]                 cnt_q;
    logic [fplb_pkg::MEAS_W-1:0] max_q;
    logic                        pend_q;
    wire  above  = w.samp_vld && (w.samp > w.logged) && (!run_q || w.samp > max_q);
    wire  end_w  = run_q && (cnt_q == 32'h0000_0001);

    assign w.peak   = max_q;
    assign w.expire = pend_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            run_q  <= 1'b0;
            cnt_q  <= '0;
            max_q  <= fplb_pkg::PEAK_INIT;
            pend_q <= 1'b0;
        end else begin
            if (above && !run_q && !pend_q) begin
                run_q <= 1'b1;
                cnt_q <= WIN_CYC;
            end else if (end_w) begin
                run_q  <= 1'b0;
                pend_q <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 32'h0000_0001;
            end
            if (above && !pend_q)
                max_q <= w.samp;
            if (pend_q && w.done)
                pend_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: core/fplb_top.sv
// fplb_top: fault, peak, reset-count and run-time logger in front of flash
// assumes flash port accepts one word per fw_vld/fw_rdy handshake;
// supply monitor code in millivolts arrives from an unsynchronised converter
//
// What this block does
// - log faults and reset count to flash
// - track per-rail peak voltage, current, temperature
// - new peak starts 30 second window
// - window end writes only the largest value
// - keep several fault records, host readable
// - record holds rail, type, time, voltage
// - host clear returns reset count to zero
// - brownout mode writes flash only at power-down
// - run-time clock persists only in brownout mode
// - host may load run-time clock value
// - brownout when supply below 2.9 V
// - brownout mode keeps logs in SRAM only
// - brownout copies all SRAM logs to flash
// - brownout mode off unless host enables
`timescale 1ns/100ps
`default_nettype none
module fplb_top (
    input  wire logic                                clk_sys,     // system clock
    input  wire logic                                sys_rst,     // sync reset
    input  wire logic                                meas_vld,    // measurement strobe
    input  wire logic [fplb_pkg::RAIL_W-1:0]         meas_rail,   // rail index
    input  wire logic [fplb_pkg::QTY_W-1:0]          meas_qty,    // 0 volt 1 current 2 temp
    input  wire logic [fplb_pkg::MEAS_W-1:0]         meas_val,    // measured value
    input  wire logic                                fault_vld,   // fault event strobe
    input  wire logic [fplb_pkg::RAIL_W-1:0]         fault_rail,  // faulted rail
    input  wire logic [fplb_pkg::TYPE_W-1:0]         fault_type,  // fault category
    input  wire logic [fplb_pkg::MEAS_W-1:0]         supply_mv,   // async supply code
    input  wire logic                                host_rstc_clr, // clear reset count
    input  wire logic                                host_rtc_ld, // load run-time clock
    input  wire logic [fplb_pkg::RTC_W-1:0]          host_rtc_val, // run-time clock value
    input  wire logic                                host_bo_en,  // misc config brownout enable
    input  wire logic                                host_bo_we,  // misc config write strobe
    input  wire logic [fplb_pkg::FIDX_W-1:0]         host_frd_idx, // fault record to read
    input  wire logic [fplb_pkg::PIDX_W-1:0]         host_prd_idx, // peak to read
    input  wire logic                                nv_bo_en,    // brownout enable from flash
    input  wire logic [fplb_pkg::RTC_W-1:0]          nv_rtc,      // stored run-time clock
    input  wire logic [fplb_pkg::RST_CNT_W-1:0]      nv_rstc,     // stored reset count
    output logic [fplb_pkg::FREC_W-1:0]              host_frd_data, // fault record read data
    output logic [fplb_pkg::MEAS_W-1:0]              host_prd_data, // peak read data
    output logic [fplb_pkg::FIDX_W:0]                fault_cnt,   // records held
    output logic [fplb_pkg::RST_CNT_W-1:0]           rst_cnt,     // reset count
    output logic [fplb_pkg::RTC_W-1:0]               rtc,         // run-time clock
    output logic                                     bo_mode,     // brownout mode active
    output logic                                     bo_event,    // brownout seen, level
    output logic                                     fw_vld,      // flash write request
    input  wire logic                                fw_rdy,      // flash write accept
    output logic [1:0]                               fw_kind,     // record kind
    output logic [fplb_pkg::PIDX_W-1:0]              fw_addr,     // slot index
    output logic [fplb_pkg::FREC_W-1:0]              fw_data      // record payload
);
    localparam int unsigned N = fplb_pkg::NUM_PEAKS;

    fplb_pkg::fplb_state_t st_q, st_d;

    logic [fplb_pkg::MEAS_W-1:0]     sup_s1_q, sup_s2_q;
    logic                            bo_q, bo_seen_q, bo_en_q;
    logic [fplb_pkg::RTC_W-1:0]      rtc_q;
    logic [fplb_pkg::RST_CNT_W-1:0]  rstc_q;
    logic                            rstc_dirty_q;
    logic [fplb_pkg::MEAS_W-1:0]     peak_q [N];
    logic [fplb_pkg::MEAS_W-1:0]     volt_q [fplb_pkg::NUM_RAILS];
    logic [fplb_pkg::FREC_W-1:0]     frec_q [fplb_pkg::NUM_FAULTS];
    logic [fplb_pkg::FIDX_W:0]       fcnt_q;
    logic [fplb_pkg::FIDX_W:0]       fflush_q;
    logic [fplb_pkg::PIDX_W-1:0]     dump_q;
    logic [1:0]                      dkind_q;
    logic                            fw_vld_q;
    logic [1:0]                      fw_kind_q;
    logic [fplb_pkg::PIDX_W-1:0]     fw_addr_q;
    logic [fplb_pkg::FREC_W-1:0]     fw_data_q;
    logic [fplb_pkg::FREC_W-1:0]     frd_q;
    logic [fplb_pkg::MEAS_W-1:0]     prd_q;
    wire  [N-1:0]                    exp_v, done_v;
    wire  [fplb_pkg::MEAS_W-1:0]     wpk_v [N];

    // one window per rail and quantity
    for (genvar g = 0; g < N; g++) begin : g_win
        fplb_win_if wi ();
        assign wi.samp_vld = meas_vld && (32'(meas_rail) * fplb_pkg::NUM_QTY + 32'(meas_qty) == g);
        assign wi.samp     = meas_val;
        assign wi.logged   = peak_q[g];
        assign wi.done     = done_v[g];
        assign exp_v[g]    = wi.expire;
        assign wpk_v[g]    = wi.peak;
        fplb_peak_win u_win (
            .clk_sys (clk_sys),
            .sys_rst (sys_rst),
            .w       (wi)
        );
    end

    // lowest pending window is served first
    logic [fplb_pkg::PIDX_W-1:0] pend_idx;
    logic                        pend_any;
    always_comb begin
        pend_idx = '0;
        pend_any = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (exp_v[i]) begin
                pend_idx = fplb_pkg::PIDX_W'(i);
                pend_any = 1'b1;
            end
        end
    end

    wire fw_take    = fw_vld_q && fw_rdy;
    wire bo_trip    = sup_s2_q < fplb_pkg::BROWNOUT_MV;
    wire fault_in   = fault_vld && (fcnt_q < (fplb_pkg::FIDX_W+1)'(fplb_pkg::NUM_FAULTS));
    wire [fplb_pkg::FIDX_W-1:0] fault_slot = fcnt_q[fplb_pkg::FIDX_W-1:0];
    wire flash_live = !bo_en_q && st_q == fplb_pkg::FPLB_IDLE && !fw_vld_q;
    wire wr_peak    = flash_live && pend_any;
    wire wr_fault   = flash_live && !pend_any && fflush_q < fcnt_q;
    wire wr_rstc    = flash_live && !pend_any && !(fflush_q < fcnt_q) && rstc_dirty_q;
    wire win_ack    = pend_any && (bo_en_q || wr_peak);

    for (genvar g = 0; g < N; g++) begin : g_ack
        assign done_v[g] = win_ack && pend_idx == fplb_pkg::PIDX_W'(g);
    end

    always_comb begin
        st_d = st_q;
        case (st_q)
            fplb_pkg::FPLB_BOOT:  st_d = fplb_pkg::FPLB_IDLE;
            fplb_pkg::FPLB_IDLE:  if (bo_en_q && bo_trip && !bo_seen_q) st_d = fplb_pkg::FPLB_DUMP;
            fplb_pkg::FPLB_DUMP:  if (fw_take && dkind_q == fplb_pkg::FW_RTC) st_d = fplb_pkg::FPLB_IDLE;
            fplb_pkg::FPLB_WRITE: st_d = fplb_pkg::FPLB_IDLE;
            default:              st_d = fplb_pkg::FPLB_IDLE;
        endcase
    end

    // dump sequence: peaks, faults, reset count, run-time clock
    wire dump_last_pk = dump_q == fplb_pkg::PIDX_W'(N - 1);
    wire dump_last_ft = dump_q == fplb_pkg::PIDX_W'(fcnt_q) - 6'h01 || fcnt_q == '0;

    always_ff @(posedge clk_sys) begin
        sup_s1_q <= supply_mv;
        sup_s2_q <= sup_s1_q;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q      <= fplb_pkg::FPLB_BOOT;
            bo_en_q   <= 1'b0;
            bo_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == fplb_pkg::FPLB_BOOT)
                bo_en_q <= nv_bo_en;
            else if (host_bo_we)
                bo_en_q <= host_bo_en;
            if (st_q == fplb_pkg::FPLB_IDLE && st_d == fplb_pkg::FPLB_DUMP)
                bo_seen_q <= 1'b1;
        end
    end

    // run-time clock, seconds from a one-cycle prescale enable chain
    logic [25:0] pre_q;
    wire sec_tick = pre_q == 26'(fplb_pkg::CLK_HZ - 1);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pre_q     <= '0;
            rtc_q     <= fplb_pkg::RTC_INIT;
        end else begin
            pre_q <= sec_tick ? '0 : pre_q + 26'h000_0001;
            if (st_q == fplb_pkg::FPLB_BOOT)
                rtc_q <= nv_bo_en ? nv_rtc : fplb_pkg::RTC_INIT;
            else if (host_rtc_ld)
                rtc_q <= host_rtc_val;
            else if (sec_tick)
                rtc_q <= rtc_q + 32'h0000_0001;
        end
    end

    // reset count: bumped once per device reset, cleared by host
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rstc_q       <= fplb_pkg::RST_CNT_INIT;
            rstc_dirty_q <= 1'b0;
        end else if (st_q == fplb_pkg::FPLB_BOOT) begin
            rstc_q       <= nv_rstc + 16'h0001;
            rstc_dirty_q <= 1'b1;
        end else if (host_rstc_clr) begin
            rstc_q       <= fplb_pkg::RST_CNT_INIT;
            rstc_dirty_q <= 1'b1;
        end else if (wr_rstc) begin
            rstc_dirty_q <= 1'b0;
        end
    end

    // working copies: peaks, last voltage per rail, fault records
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) peak_q[i] <= fplb_pkg::PEAK_INIT;
            for (int i = 0; i < fplb_pkg::NUM_RAILS; i++) volt_q[i] <= '0;
            fcnt_q <= '0;
        end else begin
            if (win_ack)
                peak_q[pend_idx] <= wpk_v[pend_idx];
            if (meas_vld && meas_qty == 2'h0 && 32'(meas_rail) < fplb_pkg::NUM_RAILS)
                volt_q[meas_rail] <= meas_val;
            if (fault_in) begin
                frec_q[fault_slot] <= {fault_rail, fault_type, rtc_q, volt_q[fault_rail]};
                fcnt_q <= fcnt_q + 5'h01;
            end
        end
    end

    // flash write port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fw_vld_q  <= 1'b0;
            fw_kind_q <= fplb_pkg::FW_PEAK;
            fw_addr_q <= '0;
            fw_data_q <= '0;
            fflush_q  <= '0;
            dump_q    <= '0;
            dkind_q   <= fplb_pkg::FW_PEAK;
        end else begin
            if (fw_take)
                fw_vld_q <= 1'b0;
            if (wr_peak) begin
                fw_vld_q  <= 1'b1;
                fw_kind_q <= fplb_pkg::FW_PEAK;
                fw_addr_q <= pend_idx;
                fw_data_q <= fplb_pkg::FREC_W'(wpk_v[pend_idx]);
            end else if (wr_fault) begin
                fw_vld_q  <= 1'b1;
                fw_kind_q <= fplb_pkg::FW_FAULT;
                fw_addr_q <= fplb_pkg::PIDX_W'(fflush_q);
                fw_data_q <= frec_q[fflush_q[fplb_pkg::FIDX_W-1:0]];
                fflush_q  <= fflush_q + 5'h01;
            end else if (wr_rstc) begin
                fw_vld_q  <= 1'b1;
                fw_kind_q <= fplb_pkg::FW_RSTC;
                fw_addr_q <= '0;
                fw_data_q <= fplb_pkg::FREC_W'(rstc_q);
            end else if (st_q == fplb_pkg::FPLB_DUMP && (!fw_vld_q || fw_take)) begin
                fw_vld_q  <= 1'b1;
                fw_kind_q <= dkind_q;
                fw_addr_q <= dump_q;
                case (dkind_q)
                    fplb_pkg::FW_PEAK:  fw_data_q <= fplb_pkg::FREC_W'(peak_q[dump_q]);
                    fplb_pkg::FW_FAULT: fw_data_q <= frec_q[dump_q[fplb_pkg::FIDX_W-1:0]];
                    fplb_pkg::FW_RSTC:  fw_data_q <= fplb_pkg::FREC_W'(rstc_q);
                    default:            fw_data_q <= fplb_pkg::FREC_W'(rtc_q);
                endcase
                dump_q <= '0;
                if (dkind_q == fplb_pkg::FW_PEAK && !dump_last_pk)
                    dump_q <= dump_q + 6'h01;
                else if (dkind_q == fplb_pkg::FW_FAULT && !dump_last_ft)
                    dump_q <= dump_q + 6'h01;
                else if (dkind_q == fplb_pkg::FW_PEAK)
                    dkind_q <= (fcnt_q == '0) ? fplb_pkg::FW_RSTC : fplb_pkg::FW_FAULT;
                else if (dkind_q != fplb_pkg::FW_RTC)
                    dkind_q <= dkind_q + 2'h1;
            end
        end
    end

    // host read data from flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            frd_q <= '0;
            prd_q <= '0;
        end else begin
            frd_q <= (5'(host_frd_idx) < fcnt_q) ? frec_q[host_frd_idx] : '0;
            prd_q <= (32'(host_prd_idx) < N) ? peak_q[host_prd_idx] : '0;
        end
    end

    assign host_frd_data = frd_q;
    assign host_prd_data = prd_q;
    assign fault_cnt     = fcnt_q;
    assign rst_cnt       = rstc_q;
    assign rtc           = rtc_q;
    assign bo_mode       = bo_en_q;
    assign bo_event      = bo_seen_q;
    assign fw_vld        = fw_vld_q;
    assign fw_kind       = fw_kind_q;
    assign fw_addr       = fw_addr_q;
    assign fw_data       = fw_data_q;
endmodule
`default_nettype wire

// file: dv/fplb_top_assertions.sv
// fplb_top_assertions: port-level checks of the log controller
// assumes it is bound onto fplb_top, one clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module fplb_chk (
    input wire logic        clk_sys,       // clock
    input wire logic        sys_rst,       // sync reset
    input wire logic        fault_vld,     // fault strobe
    input wire logic [11:0] supply_mv,     // supply code
    input wire logic        host_rstc_clr, // count clear
    input wire logic        host_rtc_ld,   // clock load
    input wire logic [31:0] host_rtc_val,  // load value
    input wire logic [3:0]  host_frd_idx,  // record select
    input wire logic [5:0]  host_prd_idx,  // peak select
    input wire logic [51:0] host_frd_data, // record data
    input wire logic [11:0] host_prd_data, // peak data
    input wire logic [4:0]  fault_cnt,     // records held
    input wire logic [15:0] rst_cnt,       // reset count
    input wire logic [31:0] rtc,           // run-time clock
    input wire logic        bo_mode,       // brownout mode
    input wire logic        bo_event,      // brownout seen
    input wire logic        fw_vld,        // write request
    input wire logic        fw_rdy,        // write accept
    input wire logic [1:0]  fw_kind,       // record kind
    input wire logic [5:0]  fw_addr,       // slot
    input wire logic [51:0] fw_data        // payload
);
    localparam logic [11:0] TH = fplb_pkg::BROWNOUT_MV;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_hold;
        fw_vld && !fw_rdy |=> fw_vld && $stable({fw_kind, fw_addr, fw_data});
    endproperty
    a_hold: assert property (p_hold) else $error("flash write changed before accept");
    property p_clr;
        host_rstc_clr |=> rst_cnt == fplb_pkg::RST_CNT_INIT;
    endproperty
    a_clr: assert property (p_clr) else $error("reset count not cleared");
    property p_ld;
        host_rtc_ld |=> rtc == $past(host_rtc_val);
    endproperty
    a_ld: assert property (p_ld) else $error("run-time clock not loaded");
    property p_quiet;
        bo_mode && !bo_event && !fw_vld |=> !fw_vld || bo_event;
    endproperty
    a_quiet: assert property (p_quiet) else $error("flash write in brownout mode");
    property p_lo;
        (bo_mode && supply_mv < TH) [*3] |-> ##[0:3] bo_event;
    endproperty
    a_lo: assert property (p_lo) else $error("low supply not flagged");
    property p_hi;
        (!bo_event && supply_mv >= TH) [*4] |=> !bo_event;
    endproperty
    a_hi: assert property (p_hi) else $error("brownout flagged at good supply");
    property p_sticky;
        bo_event |=> bo_event;
    endproperty
    a_sticky: assert property (p_sticky) else $error("brownout flag dropped");
    property p_inc;
        fault_vld && fault_cnt < 5'd10 |=> fault_cnt == $past(fault_cnt) + 5'd1;
    endproperty
    a_inc: assert property (p_inc) else $error("fault not stored");
    property p_full;
        fault_cnt >= 5'd10 |=> fault_cnt == 5'd10;
    endproperty
    a_full: assert property (p_full) else $error("fault store overran");
    property p_frd0;
        host_frd_idx >= 4'd10 |=> host_frd_data == '0;
    endproperty
    a_frd0: assert property (p_frd0) else $error("unused record read not zero");
    property p_prd0;
        host_prd_idx >= 6'd36 |=> host_prd_data == '0;
    endproperty
    a_prd0: assert property (p_prd0) else $error("unused peak read not zero");
    property p_rtcw;
        fw_vld && fw_kind == fplb_pkg::FW_RTC |-> bo_event;
    endproperty
    a_rtcw: assert property (p_rtcw) else $error("clock written without brownout");
    property p_slot;
        fw_vld && fw_kind == fplb_pkg::FW_PEAK |-> fw_addr < 6'd36;
    endproperty
    a_slot: assert property (p_slot) else $error("peak slot out of range");
endmodule
bind fplb_top fplb_chk u_chk (.clk_sys, .sys_rst, .fault_vld, .supply_mv, .host_rstc_clr, .host_rtc_ld,
    .host_rtc_val, .host_frd_idx, .host_prd_idx, .host_frd_data, .host_prd_data, .fault_cnt, .rst_cnt,
    .rtc, .bo_mode, .bo_event, .fw_vld, .fw_rdy, .fw_kind, .fw_addr, .fw_data);
`default_nettype wire

// file: dv/fplb_flash_model.sv
// fplb_flash_model: flash port acceptor, prompt or slow ready
// assumes the design holds fw_* until accepted
`timescale 1ns/100ps
`default_nettype none
module fplb_flash_model (
    input  wire logic       clk_sys,    // clock
    input  wire logic       sys_rst,    // sync reset, clears counts
    input  wire logic       slow,       // three extra wait cycles
    input  wire logic       fw_vld,     // write request
    input  wire logic [1:0] fw_kind,    // record kind
    output logic            fw_rdy,     // write accept
    output int              n_wr,       // writes taken
    output int              n_flt,      // fault writes taken
    output logic [1:0]      first_kind, // kind of first write
    output logic [1:0]      last_kind   // kind of latest write
);
    int wait_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fw_rdy     <= 1'b0;
            wait_q     <= 0;
            n_wr       <= 0;
            n_flt      <= 0;
            first_kind <= 2'h0;
            last_kind  <= 2'h0;
        end else if (fw_vld && fw_rdy) begin
            fw_rdy    <= 1'b0;
            wait_q    <= 0;
            n_wr      <= n_wr + 1;
            n_flt     <= n_flt + int'(fw_kind == fplb_pkg::FW_FAULT);
            last_kind <= fw_kind;
            if (n_wr == 0)
                first_kind <= fw_kind;
        end else if (fw_vld) begin
            wait_q <= wait_q + 1;
            fw_rdy <= (wait_q >= (slow ? 3 : 0));
        end
    end
endmodule
`default_nettype wire

// file: dv/test_fplb_top.sv
// test_fplb_top: scenario bench for the log controller
// assumes a 40 MHz clk_sys and a flash acceptor model
`timescale 1ns/100ps
`default_nettype none
module test_fplb_top;
    logic        clk_sys, sys_rst, meas_vld, fault_vld, host_rstc_clr, host_rtc_ld, host_bo_en, host_bo_we;
    logic        nv_bo_en, fw_rdy, bo_mode, bo_event, fw_vld, slow;
    logic [3:0]  meas_rail, fault_rail, fault_type, host_frd_idx;
    logic [1:0]  meas_qty, fw_kind, first_kind, last_kind;
    logic [11:0] meas_val, supply_mv, host_prd_data;
    logic [31:0] host_rtc_val, nv_rtc, rtc;
    logic [15:0] nv_rstc, rst_cnt;
    logic [5:0]  host_prd_idx, fw_addr;
    logic [51:0] host_frd_data, fw_data;
    logic [4:0]  fault_cnt;
    int          n_wr, n_flt, num_errors, num_checks, cyc;

    fplb_top DUT (.clk_sys, .sys_rst, .meas_vld, .meas_rail, .meas_qty, .meas_val, .fault_vld, .fault_rail,
        .fault_type, .supply_mv, .host_rstc_clr, .host_rtc_ld, .host_rtc_val, .host_bo_en, .host_bo_we,
        .host_frd_idx, .host_prd_idx, .nv_bo_en, .nv_rtc, .nv_rstc, .host_frd_data, .host_prd_data, .fault_cnt,
        .rst_cnt, .rtc, .bo_mode, .bo_event, .fw_vld, .fw_rdy, .fw_kind, .fw_addr, .fw_data);
    fplb_flash_model u_flash (.clk_sys, .sys_rst, .slow, .fw_vld, .fw_kind, .fw_rdy, .n_wr, .n_flt,
        .first_kind, .last_kind);

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_reset(input logic bo, input logic [31:0] t, input logic [15:0] c);
        @(posedge clk_sys);
        sys_rst  <= 1'b1;
        nv_bo_en <= bo;
        nv_rtc   <= t;
        nv_rstc  <= c;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic wait_wr(input int n);
        for (int i = 0; i < 3000 && n_wr < n; i++) begin
            @(negedge clk_sys);
        end
    endtask

    task automatic send_meas(input logic [3:0] r, input logic [1:0] q, input logic [11:0] v);
        @(posedge clk_sys);
        meas_vld  <= 1'b1;
        meas_rail <= r;
        meas_qty  <= q;
        meas_val  <= v;
        @(posedge clk_sys);
        meas_vld <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] fi, input logic [5:0] pi);
        @(posedge clk_sys);
        host_frd_idx <= fi;
        host_prd_idx <= pi;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic t_boot_plain;
        do_reset(1'b0, 32'h0000_1234, 16'h0005);
        chk("rst_cnt", rst_cnt, 64'h6);
        chk("rtc", rtc, 64'h0);
        chk("bo_mode", bo_mode, 64'h0);
        wait_wr(1);
        chk("first_kind", first_kind, fplb_pkg::FW_RSTC);
    endtask

    task automatic t_host;
        @(posedge clk_sys);
        host_rtc_ld   <= 1'b1;
        host_rtc_val  <= 32'hdead_beef;
        host_rstc_clr <= 1'b1;
        {host_bo_we, host_bo_en} <= 2'b11;
        @(posedge clk_sys);
        {host_rtc_ld, host_rstc_clr, host_bo_en} <= '0;
        @(negedge clk_sys);
        chk("rtc", rtc, 64'hdead_beef);
        chk("rst_cnt", rst_cnt, 64'h0);
        @(posedge clk_sys);
        host_bo_we <= 1'b0;
        @(negedge clk_sys);
        chk("bo_mode_off", bo_mode, 64'h0);
    endtask

    task automatic t_faults;
        send_meas(4'h3, 2'h0, 12'h456);
        // 12 faults, last two dropped
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            fault_vld  <= 1'b1;
            fault_rail <= 4'h3;
            fault_type <= 4'(i);
        end
        @(posedge clk_sys);
        fault_vld <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("fault_cnt", fault_cnt, 64'd10);
        rd(4'h0, 6'd40);
        chk("rec0", host_frd_data, {4'h3, 4'h0, 32'hdead_beef, 12'h456});
        chk("peak40", host_prd_data, 64'h0);
        rd(4'h9, 6'd0);
        chk("rec9", host_frd_data, {4'h3, 4'h9, 32'hdead_beef, 12'h456});
        rd(4'hc, 6'd0);
        chk("rec12", host_frd_data, 64'h0);
        repeat (120) @(negedge clk_sys);
        chk("fault_writes", n_flt, 64'd10);
    endtask

    task automatic t_brownout;
        slow <= 1'b1;
        do_reset(1'b1, 32'h0000_0100, 16'h0009);
        chk("rst_cnt", rst_cnt, 64'ha);
        chk("rtc", rtc, 64'h100);
        chk("bo_mode", bo_mode, 64'h1);
        send_meas(4'h7, 2'h2, 12'h0ff);
        @(posedge clk_sys);
        fault_vld  <= 1'b1;
        fault_rail <= 4'h7;
        fault_type <= 4'h2;
        @(posedge clk_sys);
        fault_vld <= 1'b0;
        supply_mv <= 12'hb54;
        repeat (20) @(negedge clk_sys);
        chk("writes_held", n_wr, 64'd0);
        chk("bo_event_edge", bo_event, 64'h0);
        @(posedge clk_sys);
        supply_mv <= 12'hb53;
        repeat (6) @(negedge clk_sys);
        chk("bo_event", bo_event, 64'h1);
        wait_wr(39);
        repeat (50) @(negedge clk_sys);
        chk("dump_writes", n_wr, 64'd39);
        chk("dump_last", last_kind, fplb_pkg::FW_RTC);
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        cyc = 0;
        num_errors = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        slow = 1'b0;
        {meas_vld, fault_vld, host_rstc_clr, host_rtc_ld, host_bo_en, host_bo_we, nv_bo_en} = '0;
        {meas_rail, fault_rail, fault_type, host_frd_idx, meas_qty, meas_val} = '0;
        {host_rtc_val, nv_rtc, nv_rstc, host_prd_idx} = '0;
        supply_mv = 12'hce4;
        t_boot_plain();
        t_host();
        t_faults();
        t_brownout();
        summarize();
    end
endmodule
`default_nettype wire
